// File: rtl/sar_params.svh
// Constants for the successive-approximation readout sequencer.
// Assumes inclusion by the package, the sequencer and the bench top.
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// Result width and bit positions
`define SAR_RESULT_BITS    12
`define SAR_IDX_MSB        4'hB
`define SAR_IDX_LSB        4'h0
`define SAR_IDX_REV_FIRST  4'h1
`define SAR_IDX_REV_END    4'hC

// Trial code for the first decision (midscale)
`define SAR_TRIAL_MSB      12'h800
`define SAR_RESULT_RST     12'h000

// Falling shift-clock edges spent sampling
`define SAR_SAMPLE_FALLS   2

`endif

// File: rtl/sar_pkg.sv
// Types for the successive-approximation readout sequencer.
// Assumes the constants header sits beside it.
`include "sar_params.svh"

package sar_pkg;

    // Sequencer phases, one-hot
    typedef enum logic [5:0] {
        SAR_IDLE    = 6'b00_0001,
        SAR_SAMPLE  = 6'b00_0010,
        SAR_NULL    = 6'b00_0100,
        SAR_CONV    = 6'b00_1000,
        SAR_REVERSE = 6'b01_0000,
        SAR_DONE    = 6'b10_0000
    } sar_phase_e;

    // Whole sequencer state
    typedef struct packed {
        logic                         sel_s1;
        logic                         sel_s2;
        logic                         sel_s3;
        logic                         sclk_s1;
        logic                         sclk_s2;
        logic                         sclk_s3;
        logic                         cmp_s1;
        logic                         cmp_s2;
        sar_phase_e                   phase;
        logic                         fall_cnt;
        logic [3:0]                   idx;
        logic [`SAR_RESULT_BITS-1:0]  result;
        logic [`SAR_RESULT_BITS-1:0]  trial;
        logic                         dout;
        logic                         dout_oe;
        logic                         sampling;
        logic                         shutdown;
    } sar_state_s;

    // Pin-facing outputs grouped together
    typedef struct packed {
        logic                         serial_data_out;
        logic                         serial_data_oe;
    } sar_serial_s;

endpackage : sar_pkg

// File: rtl/sar_adc_serial_readout.sv
// Conversion sequencer and serial result port of a 12-bit SAR converter.
// Assumes select and shift clock arrive asynchronously from a host pin,
// and that the analog comparator level is also asynchronous to clk.
`timescale 1ns/100ps
`include "sar_params.svh"

module sar_adc_serial_readout
    import sar_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // Host pins
    input  wire logic                         select_n_shutdown,
    input  wire logic                         conversion_shift_clock,
    output sar_serial_s                       serial_pins,
    // Analog array side
    input  wire logic                         comparator_high,
    output logic [`SAR_RESULT_BITS-1:0]       dac_trial_code,
    output logic                              sample_active,
    output logic                              shutdown_active
);

    sar_state_s state_reg;
    sar_state_s state_next;

    logic sel_high;
    logic sel_fall;
    logic sclk_fall;

    // Edge detects read only the second and third synchroniser stages
    assign sel_high  = state_reg.sel_s2;
    assign sel_fall  = state_reg.sel_s3 & ~state_reg.sel_s2;
    assign sclk_fall = state_reg.sclk_s3 & ~state_reg.sclk_s2;

    // Next-state logic
    always_comb
    begin
        state_next         = state_reg;
        state_next.sel_s1  = select_n_shutdown;
        state_next.sel_s2  = state_reg.sel_s1;
        state_next.sel_s3  = state_reg.sel_s2;
        state_next.sclk_s1 = conversion_shift_clock;
        state_next.sclk_s2 = state_reg.sclk_s1;
        state_next.sclk_s3 = state_reg.sclk_s2;
        state_next.cmp_s1  = comparator_high;
        state_next.cmp_s2  = state_reg.cmp_s1;
        state_next.shutdown = sel_high;
        if (sel_high)
        begin
            // Abort or shutdown: result kept, port released
            state_next.phase    = SAR_IDLE;
            state_next.dout_oe  = 1'b0;
            state_next.dout     = 1'b0;
            state_next.sampling = 1'b0;
            state_next.fall_cnt = 1'b0;
        end
        else
        begin
            unique case (state_reg.phase)
                SAR_IDLE:
                begin
                    // Only a real high-to-low select starts work
                    if (sel_fall)
                    begin
                        state_next.phase    = SAR_SAMPLE;
                        state_next.sampling = 1'b1;
                        state_next.fall_cnt = 1'b0;
                        state_next.result   = `SAR_RESULT_RST;
                        state_next.trial    = `SAR_RESULT_RST;
                    end
                end
                SAR_SAMPLE:
                begin
                    if (sclk_fall)
                    begin
                        state_next.fall_cnt = 1'b1;
                        if (state_reg.fall_cnt)
                        begin
                            // Second fall: hold, enable port, null bit
                            state_next.phase    = SAR_NULL;
                            state_next.sampling = 1'b0;
                            state_next.dout_oe  = 1'b1;
                            state_next.dout     = 1'b0;
                            state_next.idx      = `SAR_IDX_MSB;
                            state_next.trial    = `SAR_TRIAL_MSB;
                        end
                    end
                end
                SAR_NULL, SAR_CONV:
                begin
                    // Decision latched on the fall and driven out at once
                    if (sclk_fall)
                    begin
                        state_next.result[state_reg.idx] = state_reg.cmp_s2;
                        state_next.dout = state_reg.cmp_s2;
                        if (state_reg.idx == `SAR_IDX_LSB)
                        begin
                            state_next.phase = SAR_REVERSE;
                            state_next.idx   = `SAR_IDX_REV_FIRST;
                            state_next.trial = state_next.result;
                        end
                        else
                        begin
                            state_next.phase = SAR_CONV;
                            state_next.idx   = state_reg.idx - 4'h1;
                            state_next.trial = state_next.result;
                            state_next.trial[state_reg.idx - 4'h1] = 1'b1;
                        end
                    end
                end
                SAR_REVERSE:
                begin
                    if (sclk_fall)
                    begin
                        if (state_reg.idx == `SAR_IDX_REV_END)
                        begin
                            state_next.phase   = SAR_DONE;
                            state_next.dout_oe = 1'b0;
                            state_next.dout    = 1'b0;
                        end
                        else
                        begin
                            state_next.dout = state_reg.result[state_reg.idx];
                            state_next.idx  = state_reg.idx + 4'h1;
                        end
                    end
                end
                SAR_DONE:
                begin
                    // Clocks ignored until select goes high again
                    state_next.dout_oe = 1'b0;
                end
                default:
                begin
                    state_next.phase = SAR_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            // Select stages clear low: a pin held low through reset never reads as a fall
            state_reg          <= '0;
            state_reg.phase    <= SAR_IDLE;
            state_reg.shutdown <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign serial_pins.serial_data_out = state_reg.dout;
    assign serial_pins.serial_data_oe  = state_reg.dout_oe;
    assign dac_trial_code              = state_reg.trial;
    assign sample_active               = state_reg.sampling;
    assign shutdown_active             = state_reg.shutdown;

    // Checks
    property p_start;
        @(posedge clk) disable iff (reset)
        (state_reg.phase == SAR_IDLE && sel_fall && !sel_high) |=> state_reg.phase == SAR_SAMPLE;
    endproperty
    a_start: assert property (p_start) else $error("select fall did not start sampling");

    property p_sample_quiet;
        @(posedge clk) disable iff (reset)
        state_reg.phase == SAR_SAMPLE |-> (!state_reg.dout_oe && state_reg.sampling);
    endproperty
    a_sample_quiet: assert property (p_sample_quiet) else $error("port active while sampling");

    property p_null_bit;
        @(posedge clk) disable iff (reset)
        (state_reg.phase == SAR_SAMPLE && state_reg.fall_cnt && sclk_fall && !sel_high)
        |=> (state_reg.dout_oe && !state_reg.dout && state_reg.trial == `SAR_TRIAL_MSB);
    endproperty
    a_null_bit: assert property (p_null_bit) else $error("null bit not driven low");

    property p_decision_out;
        @(posedge clk) disable iff (reset)
        ((state_reg.phase == SAR_NULL || state_reg.phase == SAR_CONV) && sclk_fall && !sel_high)
        |=> state_reg.dout == $past(state_reg.cmp_s2);
    endproperty
    a_decision_out: assert property (p_decision_out) else $error("decided bit not presented");

    property p_change_on_fall;
        @(posedge clk) disable iff (reset)
        (state_reg.dout_oe && $changed(state_reg.dout)) |-> $past(sclk_fall);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall) else $error("output moved off a falling edge");

    property p_reverse_bit;
        @(posedge clk) disable iff (reset)
        (state_reg.phase == SAR_REVERSE && sclk_fall && !sel_high && state_reg.idx != `SAR_IDX_REV_END)
        |=> state_reg.dout == $past(state_reg.result[state_reg.idx]);
    endproperty
    a_reverse_bit: assert property (p_reverse_bit) else $error("reverse bit mismatch");

    property p_done_quiet;
        @(posedge clk) disable iff (reset)
        state_reg.phase == SAR_DONE |-> !state_reg.dout_oe ##1 (state_reg.phase != SAR_CONV);
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("port active after resend");

    property p_shutdown;
        @(posedge clk) disable iff (reset)
        sel_high |=> (state_reg.phase == SAR_IDLE && !state_reg.dout_oe && state_reg.shutdown);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("select high did not shut down");

    property p_no_restart;
        @(posedge clk) disable iff (reset)
        (state_reg.phase == SAR_DONE && !sel_high) |=> state_reg.phase == SAR_DONE;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("restart without select toggle");

    // Steps of a decision and of an abort
    sequence s_conv_fall;
        (state_reg.phase == SAR_NULL || state_reg.phase == SAR_CONV) && sclk_fall && !sel_high;
    endsequence
    sequence s_lsb_fall;
        s_conv_fall ##0 (state_reg.idx == `SAR_IDX_LSB);
    endsequence
    sequence s_abort_seen;
        sel_high && state_reg.phase != SAR_IDLE;
    endsequence
    sequence s_port_released;
        state_reg.phase == SAR_IDLE && !state_reg.dout_oe && !state_reg.sampling;
    endsequence

    property p_no_idle_start;
        @(posedge clk) disable iff (reset)
        (state_reg.phase == SAR_IDLE && !sel_fall) |=> state_reg.phase != SAR_SAMPLE;
    endproperty
    a_no_idle_start: assert property (p_no_idle_start) else $error("sampling began without a select fall");

    property p_sample_hold;
        @(posedge clk) disable iff (reset)
        (state_reg.phase == SAR_SAMPLE && !state_reg.fall_cnt && !sel_high)
        |=> (state_reg.phase == SAR_SAMPLE && state_reg.sampling);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("sampling cut short after first fall");

    property p_conv_step;
        @(posedge clk) disable iff (reset)
        (s_conv_fall ##0 (state_reg.idx != `SAR_IDX_LSB))
        |=> (state_reg.phase == SAR_CONV && state_reg.idx == $past(state_reg.idx) - 4'h1);
    endproperty
    a_conv_step: assert property (p_conv_step) else $error("decision index did not step down");

    property p_trial_probe;
        @(posedge clk) disable iff (reset)
        (s_conv_fall ##0 (state_reg.idx != `SAR_IDX_LSB)) |=> state_reg.trial[state_reg.idx];
    endproperty
    a_trial_probe: assert property (p_trial_probe) else $error("next trial bit not raised");

    property p_reverse_entry;
        @(posedge clk) disable iff (reset)
        s_lsb_fall |=> (state_reg.phase == SAR_REVERSE && state_reg.idx == `SAR_IDX_REV_FIRST);
    endproperty
    a_reverse_entry: assert property (p_reverse_entry) else $error("reverse phase not entered after last bit");

    property p_abort_release;
        @(posedge clk) disable iff (reset)
        s_abort_seen |=> s_port_released;
    endproperty
    a_abort_release: assert property (p_abort_release) else $error("abort did not release the port");

    property p_result_kept;
        @(posedge clk) disable iff (reset)
        sel_high |=> $stable(state_reg.result);
    endproperty
    a_result_kept: assert property (p_result_kept) else $error("result lost on select high");

    property p_selected;
        @(posedge clk) disable iff (reset)
        !sel_high |=> !state_reg.shutdown;
    endproperty
    a_selected: assert property (p_selected) else $error("shutdown while selected");

    property p_hold_between;
        @(posedge clk) disable iff (reset)
        (state_reg.dout_oe && !sclk_fall && !sel_high) |=> $stable(state_reg.dout);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("output moved between falls");

endmodule : sar_adc_serial_readout

// File: testbench/sar_host_model.sv
// Host side model: drives select and shift clock, captures serial bits.
// Assumes one fast system clock paces it; the shift clock stands high between frames.
`timescale 1ns/100ps
module sar_host_model
    import sar_pkg::*;
(
    // System clock
    input  wire logic  clk,
    // Pins towards the converter
    output logic        select_n_shutdown,
    output logic        conversion_shift_clock,
    input  sar_serial_s serial_pins
);
    // Half period of 8 clk gives 1.5625 MHz, above the 150 ns minimum phase
    localparam int HALF = 8;

    // Idle pins at time zero: deselected, clock parked high
    initial
    begin
        select_n_shutdown      = 1'b1;
        conversion_shift_clock = 1'b1;
    end

    // All pin changes land a fixed 1 ns after a rising edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // Select edges; the bench keeps high spans of 8 clk or more between samples
    task automatic set_select(input logic lvl);
        wait_clk(1);
        select_n_shutdown = lvl;
    endtask : set_select

    // Clock n falls; bit k is captured just before the rise that follows fall k
    task automatic frame(input int n, output logic [31:0] d, output logic [31:0] oe);
        d  = '0;
        oe = '0;
        wait_clk(HALF);
        for (int k = 1; k <= n; k++)
        begin
            conversion_shift_clock = 1'b0;
            wait_clk(HALF);
            // A released pin reads as the inverse, so a missing enable shows as a wrong bit
            d[k]  = serial_pins.serial_data_oe ? serial_pins.serial_data_out : ~serial_pins.serial_data_out;
            oe[k] = serial_pins.serial_data_oe;
            conversion_shift_clock = 1'b1;
            wait_clk(HALF);
        end
    endtask : frame
endmodule : sar_host_model

// File: testbench/tb_top.sv
// Self-checking bench for the converter readout sequencer.
// Assumes the host model drives the pins and an ideal comparator closes the loop.
`timescale 1ns/100ps
`include "sar_params.svh"
module tb_top;
    import sar_pkg::*;

    logic                        clk;
    logic                        reset;
    logic                        select_n_shutdown;
    logic                        conversion_shift_clock;
    sar_serial_s                 serial_pins;
    logic                        comparator_high;
    logic [`SAR_RESULT_BITS-1:0] dac_trial_code;
    logic                        sample_active;
    logic                        shutdown_active;
    logic [11:0]                 vin;
    logic [31:0]                 d;
    logic [31:0]                 oe;
    int                          n_fail;
    int                          cmp_count;

    // 25 MHz clock; reset is driven by the scenario process alone
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // Ideal comparator: high while the input code is at or above the trial code
    assign comparator_high = (dac_trial_code <= vin);

    sar_adc_serial_readout uut (
        .clk(clk), .reset(reset), .select_n_shutdown(select_n_shutdown),
        .conversion_shift_clock(conversion_shift_clock), .serial_pins(serial_pins),
        .comparator_high(comparator_high), .dac_trial_code(dac_trial_code),
        .sample_active(sample_active), .shutdown_active(shutdown_active));

    sar_host_model u_host (
        .clk(clk), .select_n_shutdown(select_n_shutdown),
        .conversion_shift_clock(conversion_shift_clock), .serial_pins(serial_pins));

    task automatic chk1(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk1

    task automatic chk12(input logic [11:0] got, input logic [11:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk12

    task automatic complete_run();
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // Deselect, then select and confirm the sample phase is entered
    task automatic start_sample();
        u_host.set_select(1'b1);
        u_host.wait_clk(8);
        chk1(shutdown_active, 1'b1, "no shutdown");
        chk1(serial_pins.serial_data_oe, 1'b0, "driven while high");
        u_host.set_select(1'b0);
        u_host.wait_clk(8);
        chk1(sample_active, 1'b1, "no sample");
        chk1(shutdown_active, 1'b0, "shutdown while low");
    endtask : start_sample

    task automatic t_reset_state();
        chk1(serial_pins.serial_data_oe, 1'b0, "oe after reset");
        chk1(shutdown_active, 1'b1, "shutdown after reset");
        chk1(sample_active, 1'b0, "sample after reset");
    endtask : t_reset_state

    // Full frame plus five idle falls with select still low
    task automatic t_full(input logic [11:0] code);
        logic [11:0] word;
        vin = code;
        start_sample();
        u_host.frame(30, d, oe);
        chk1(oe[1], 1'b0, "early enable");
        chk1(oe[2], 1'b1, "null not driven");
        chk1(d[2], 1'b0, "null not low");
        for (int i = 0; i < 12; i++)
        begin
            word[11-i] = d[3+i];
            chk1(oe[3+i], 1'b1, "forward oe");
            chk1(d[3+i], code[11-i], "forward bit");
        end
        chk12(word, code, "result word");
        for (int i = 1; i < 12; i++)
            chk1(d[14+i], code[i], "reverse bit");
        for (int k = 26; k <= 30; k++)
            chk1(oe[k], 1'b0, "not released");
    endtask : t_full

    // Abort after the sixth result bit; sent bits stay right and output releases
    task automatic t_abort();
        vin = 12'h3C6;
        start_sample();
        u_host.frame(8, d, oe);
        for (int i = 0; i < 6; i++)
            chk1(d[3+i], vin[11-i], "bit before abort");
        u_host.set_select(1'b1);
        u_host.wait_clk(6);
        chk1(serial_pins.serial_data_oe, 1'b0, "oe after abort");
        chk1(shutdown_active, 1'b1, "shutdown after abort");
    endtask : t_abort

    // Reset in mid-conversion with select held low: port quiet, no start until select toggles
    task automatic t_mid_reset();
        vin = 12'h5A3;
        start_sample();
        u_host.frame(6, d, oe);
        chk1(d[3], vin[11], "bit before mid reset");
        u_host.wait_clk(1);
        reset = 1'b1;
        u_host.wait_clk(2);
        reset = 1'b0;
        u_host.wait_clk(4);
        chk1(serial_pins.serial_data_oe, 1'b0, "oe after mid reset");
        chk1(sample_active, 1'b0, "sample after mid reset");
        chk1(shutdown_active, 1'b0, "shutdown with select low");
        chk12(dac_trial_code, 12'h000, "trial after mid reset");
        u_host.frame(4, d, oe);
        for (int k = 1; k <= 4; k++)
            chk1(oe[k], 1'b0, "start without select toggle");
        chk1(sample_active, 1'b0, "sampling without select toggle");
    endtask : t_mid_reset

    // Watchdog, far beyond the roughly 2900 clk the sequence needs
    initial
    begin
        #800000;
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    // Reset held for 8 cycles, then the scenarios in order
    initial
    begin
        n_fail    = 0;
        cmp_count = 0;
        reset     = 1'b1;
        vin       = 12'h000;
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        u_host.wait_clk(4);
        t_reset_state();
        t_full(12'hA5C);
        t_full(12'hFFF);
        t_full(12'h800);
        t_full(12'h000);
        t_abort();
        t_mid_reset();
        t_full(12'h3C6);
        complete_run();
    end
endmodule : tb_top
